// ==== shared/dmsc_pkg.sv ====
// shared constants and types for the dpll mode state control block
package dmsc_pkg;

	// ===========================================================
	// operating mode select codes
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_HOLDOVER = 2'h1;
	localparam logic [1:0] MODE_FREERUN = 2'h2;
	localparam logic [1:0] MODE_RESERVED = 2'h3;

	// ===========================================================
	// reference frequency select codes
	localparam logic [1:0] FREQ_RESERVED = 2'h0;
	localparam logic [1:0] FREQ_8K = 2'h1;
	localparam logic [1:0] FREQ_1544K = 2'h2;
	localparam logic [1:0] FREQ_2048K = 2'h3;

	// ===========================================================
	// timing
	localparam longint CLK_HZ = 250000000;
	localparam longint CLK_PERIOD_PS = 4000;
	localparam longint FRAME_HZ = 8000;
	localparam longint FRAME_CYCLES = CLK_HZ / FRAME_HZ;
	localparam longint FRAME_PULSE_NS = 122;
	localparam longint FRAME_PULSE_CYCLES = (FRAME_PULSE_NS * 1000) / CLK_PERIOD_PS;
	localparam longint STORE_MS = 30;
	localparam longint STORE_FRAMES = (STORE_MS * FRAME_HZ) / 1000;
	localparam longint LOCK_S = 30;
	localparam longint LOCK_FRAMES = LOCK_S * FRAME_HZ;
	localparam longint FAST_LOCK_MS = 500;
	localparam longint FAST_LOCK_FRAMES = (FAST_LOCK_MS * FRAME_HZ) / 1000;

	// ===========================================================
	// widths and reset values
	localparam int FREQ_W = 32;
	localparam logic [31:0] FREQ_WORD_RESET = 32'h0;
	localparam int FCNT_W = 16;
	localparam int LCNT_W = 20;

	// ===========================================================
	// mode states, one-hot
	typedef enum logic [4:0] {
		ST_FREERUN = 5'h01,
		ST_NORMAL = 5'h02,
		ST_AUTO_HOLD = 5'h04,
		ST_HOLDOVER = 5'h08,
		ST_SHORT_HOLD = 5'h10
	} dmsc_state_t;

endpackage : dmsc_pkg

// ==== logic/dmsc_core.sv ====
// mode state machine, frame timing and holdover storage of the dpll
// Function
// - decode mode pins: 00 normal, 01 holdover, 10 freerun, 11 reserved
// - every state change happens on the rising edge of the frame pulse
// - normal tracking enters automatic holdover on an invalid reference
// - auto holdover: select transient goes short holdover, else back on valid
// - select transient in normal tracking moves to short holdover, or to auto holdover if the reference is also invalid
// - mode change disables step compensation except entries into normal from states other than freerun
// - lock to reference within 30 seconds from reset in normal
// - normal status high whenever in normal tracking
// - rapid acquire in normal locks typically within 500 ms
// - locked normal stores frequency word every 30 ms, alternating slots
// - holdover uses the stored word 30 to 60 ms old
// - holdover status high whenever in holdover
// - freerun runs from the master oscillator only, ignoring references
// - freerun status high whenever in freerun
// - frequency pins: 00 reserved, 01 8 kHz, 10 1.544 MHz, 11 2.048 MHz
// - frequency choice takes effect only at reset
// - frame pulse 8 kHz, active high, 120 ns (30 cycles) at frame start
// - short holdover without further transient swaps reference, returns normal
`timescale 1ns/10ps
`default_nettype none

module dmsc_core (
	// clock, reset, enable
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic clk_en,
	// mode and select pins
	input wire logic op_mode_select_lo,
	input wire logic op_mode_select_hi,
	input wire logic ref_select,
	input wire logic ref_freq_choice_lo,
	input wire logic ref_freq_choice_hi,
	input wire logic rapid_acquire_enable,
	input wire logic phase_step_comp_request,
	// datapath status and frequency word
	input wire logic reference_invalid,
	input wire logic loop_locked,
	input wire logic [dmsc_pkg::FREQ_W-1:0] loop_freq_word,
	// frame timing
	output logic frame_pulse_active_high,
	// status and control outputs
	output logic normal_status,
	output logic holdover_status,
	output logic freerun_status,
	output logic phase_step_comp_enable,
	output logic active_reference_b,
	output logic use_master_oscillator,
	output logic limiter_bypass,
	output logic lock_timeout,
	output logic [1:0] ref_freq_active,
	output logic ref_freq_reserved,
	output logic [dmsc_pkg::FREQ_W-1:0] holdover_freq_word
);
	import dmsc_pkg::*;

	// ===========================================================
	// pin synchronisers
	logic [5:0] pin_meta;
	logic [5:0] pin_sync;
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pin_meta <= 6'h00;
			pin_sync <= 6'h00;
		end else if (clk_en) begin
			pin_meta <= {ref_freq_choice_hi, ref_freq_choice_lo, ref_select,
				op_mode_select_hi, op_mode_select_lo, rapid_acquire_enable};
			pin_sync <= pin_meta;
		end
	end
	logic [1:0] mode_pins;
	logic sel_sync;
	logic fast_sync;
	assign mode_pins = pin_sync[2:1];
	assign sel_sync = pin_sync[3];
	assign fast_sync = pin_sync[0];

	// ===========================================================
	// sync depth tracker; bit 1 marks pin_sync holding real pin levels
	logic [2:0] sync_ready;
	always_ff @(posedge ref_clk) begin
		if (reset)
			sync_ready <= 3'h0;
		else if (clk_en)
			sync_ready <= {sync_ready[1:0], 1'b1};
	end

	// ===========================================================
	// frequency choice captured on reset release only
	logic freq_loaded;
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			freq_loaded <= 1'b0;
			ref_freq_active <= FREQ_RESERVED;
		end else if (clk_en && !freq_loaded) begin
			// waits for synchronised pins; later changes need another reset
			if (sync_ready[1]) begin
				freq_loaded <= 1'b1;
				ref_freq_active <= pin_sync[5:4];
			end
		end
	end
	assign ref_freq_reserved = (ref_freq_active == FREQ_RESERVED);

	// ===========================================================
	// frame pulse generator
	logic [FCNT_W-1:0] frame_cnt;
	logic frame_edge;
	assign frame_edge = clk_en && (frame_cnt == FCNT_W'(0));
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			frame_cnt <= FCNT_W'(0);
			frame_pulse_active_high <= 1'b0;
		end else if (clk_en) begin
			if (frame_cnt == FCNT_W'(FRAME_CYCLES - 1))
				frame_cnt <= FCNT_W'(0);
			else
				frame_cnt <= frame_cnt + FCNT_W'(1);
			frame_pulse_active_high <= (frame_cnt < FCNT_W'(FRAME_PULSE_CYCLES));
		end
	end

	// ===========================================================
	// select transient detection between frame edges
	logic sel_at_edge;
	logic sel_moved;
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sel_at_edge <= 1'b0;
			sel_moved <= 1'b0;
		end else if (clk_en) begin
			if (!sync_ready[2]) begin
				// follow the pin until synced so reset fakes no swap
				sel_at_edge <= sel_sync;
				sel_moved <= 1'b0;
			end else if (frame_edge) begin
				sel_at_edge <= sel_sync;
				sel_moved <= 1'b0;
			end else if (sel_sync != sel_at_edge) begin
				sel_moved <= 1'b1;
			end
		end
	end
	logic transient;
	assign transient = sel_moved || (sel_sync != sel_at_edge);

	// ===========================================================
	// mode state machine
	dmsc_state_t state;
	dmsc_state_t next_state;
	always_comb begin
		next_state = state;
		case (state)
			ST_NORMAL: begin
				if (reference_invalid)
					next_state = ST_AUTO_HOLD;
				else if (transient)
					next_state = ST_SHORT_HOLD;
				else if (mode_pins == MODE_HOLDOVER)
					next_state = ST_HOLDOVER;
				else if (mode_pins == MODE_FREERUN)
					next_state = ST_FREERUN;
			end
			ST_AUTO_HOLD: begin
				if (transient)
					next_state = ST_SHORT_HOLD;
				else if (!reference_invalid)
					next_state = ST_NORMAL;
			end
			ST_SHORT_HOLD: begin
				if (!transient)
					next_state = ST_NORMAL;
			end
			ST_HOLDOVER: begin
				if (mode_pins == MODE_NORMAL)
					next_state = ST_NORMAL;
				else if (mode_pins == MODE_FREERUN)
					next_state = ST_FREERUN;
			end
			ST_FREERUN: begin
				if (mode_pins == MODE_NORMAL)
					next_state = ST_NORMAL;
				else if (mode_pins == MODE_HOLDOVER)
					next_state = ST_HOLDOVER;
			end
			default: next_state = ST_FREERUN;
		endcase
		// reserved code freezes the pin-driven modes
		if (mode_pins == MODE_RESERVED && (state == ST_HOLDOVER || state == ST_FREERUN))
			next_state = state;
	end

	logic comp_auto_off;
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state <= ST_NORMAL;
			comp_auto_off <= 1'b1;
		end else if (frame_edge) begin
			state <= next_state;
			if (next_state != state)
				// freerun into normal is not one of the exempt changes
				comp_auto_off <= (next_state != ST_NORMAL) || (state == ST_FREERUN);
		end
	end
	assign phase_step_comp_enable = phase_step_comp_request && !comp_auto_off;

	// ===========================================================
	// reference swap on short holdover exit
	always_ff @(posedge ref_clk) begin
		if (reset)
			active_reference_b <= 1'b0;
		else if (frame_edge && state == ST_SHORT_HOLD && next_state == ST_NORMAL)
			active_reference_b <= !active_reference_b;
	end

	// ===========================================================
	// status outputs, from the state being entered so they turn with the pulse
	dmsc_state_t shown;
	assign shown = frame_edge ? next_state : state;
	always_ff @(posedge ref_clk) begin
		if (reset)
			normal_status <= 1'b0;
		else if (clk_en)
			normal_status <= (shown == ST_NORMAL);
	end

	always_ff @(posedge ref_clk) begin
		if (reset)
			holdover_status <= 1'b0;
		else if (clk_en)
			holdover_status <= (shown != ST_NORMAL) && (shown != ST_FREERUN);
	end

	always_ff @(posedge ref_clk) begin
		if (reset)
			freerun_status <= 1'b0;
		else if (clk_en)
			freerun_status <= (shown == ST_FREERUN);
	end

	always_ff @(posedge ref_clk) begin
		if (reset)
			use_master_oscillator <= 1'b0;
		else if (clk_en)
			use_master_oscillator <= (shown == ST_FREERUN);
	end

	// bypass only in normal tracking; other modes keep the limiter path
	always_ff @(posedge ref_clk) begin
		if (reset)
			limiter_bypass <= 1'b0;
		else if (clk_en)
			limiter_bypass <= (shown == ST_NORMAL) && fast_sync;
	end

	// ===========================================================
	// lock supervision in frames
	logic [LCNT_W-1:0] lock_cnt;
	logic [LCNT_W-1:0] lock_limit;
	assign lock_limit = fast_sync ? LCNT_W'(FAST_LOCK_FRAMES) : LCNT_W'(LOCK_FRAMES);
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			lock_cnt <= LCNT_W'(0);
			lock_timeout <= 1'b0;
		end else if (frame_edge) begin
			if (state != ST_NORMAL || loop_locked) begin
				lock_cnt <= LCNT_W'(0);
				lock_timeout <= 1'b0;
			end else if (lock_cnt >= lock_limit) begin
				lock_timeout <= 1'b1;
			end else begin
				lock_cnt <= lock_cnt + LCNT_W'(1);
			end
		end
	end

	// ===========================================================
	// alternating frequency word storage
	logic [FREQ_W-1:0] store_slot [2];
	logic store_ptr;
	logic [FCNT_W-1:0] store_cnt;
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			store_slot[0] <= FREQ_WORD_RESET;
			store_slot[1] <= FREQ_WORD_RESET;
			store_ptr <= 1'b0;
			store_cnt <= FCNT_W'(0);
		end else if (frame_edge && state == ST_NORMAL && loop_locked) begin
			if (store_cnt == FCNT_W'(STORE_FRAMES - 1)) begin
				store_cnt <= FCNT_W'(0);
				store_slot[store_ptr] <= loop_freq_word;
				store_ptr <= !store_ptr;
			end else begin
				store_cnt <= store_cnt + FCNT_W'(1);
			end
		end
	end

	// ===========================================================
	// holdover word capture
	// older slot is the one the pointer will overwrite next
	always_ff @(posedge ref_clk) begin
		if (reset)
			holdover_freq_word <= FREQ_WORD_RESET;
		else if (frame_edge && state == ST_NORMAL && next_state != ST_NORMAL)
			holdover_freq_word <= store_slot[store_ptr];
	end

endmodule : dmsc_core
`default_nettype wire

// ==== sim/dmsc_host.sv ====
// host model driving the mode and frequency select pins
`timescale 1ns/10ps
`default_nettype none
module dmsc_host (
	// clock and commands
	input wire logic ref_clk,
	input wire logic [1:0] mode_cmd,
	input wire logic [1:0] freq_cmd,
	// select pins
	output logic op_mode_select_lo,
	output logic op_mode_select_hi,
	output logic ref_freq_choice_lo,
	output logic ref_freq_choice_hi
);
	// pins move only after an edge, as from a host register
	always_ff @(posedge ref_clk) begin
		{op_mode_select_hi, op_mode_select_lo} <= mode_cmd;
		{ref_freq_choice_hi, ref_freq_choice_lo} <= freq_cmd;
	end
endmodule : dmsc_host
`default_nettype wire

// ==== sim/dmsc_core_props.sv ====
// assertions on the mode control ports
`timescale 1ns/10ps
`default_nettype none
module dmsc_core_props (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic clk_en,
	// watched ports
	input wire logic rapid_acquire_enable,
	input wire logic frame_pulse_active_high,
	input wire logic normal_status,
	input wire logic holdover_status,
	input wire logic freerun_status,
	input wire logic phase_step_comp_enable,
	input wire logic use_master_oscillator,
	input wire logic limiter_bypass,
	input wire logic [1:0] ref_freq_active
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	wire logic fp = frame_pulse_active_high;
	int hi_n;
	int gap_n;
	int age;
	logic seen;
	// ===========================================================
	// pulse counters, cleared by reset so a cut pulse is not judged,
	// and frozen with the clock enable like the design
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			hi_n <= 0;
			gap_n <= 0;
			age <= 0;
			seen <= 1'b0;
		end else if (clk_en) begin
			hi_n <= fp ? hi_n + 1 : 0;
			gap_n <= (fp && hi_n == 0) ? 0 : gap_n + 1;
			age <= (age < 15) ? age + 1 : age;
			seen <= seen | (fp && hi_n == 0);
		end
	end
	sequence frame_start;
		fp && hi_n == 0;
	endsequence
	sequence fast_normal;
		(rapid_acquire_enable && normal_status && !fp) [*4];
	endsequence
	// ===========================================================
	// checks
	a_pulse_width: assert property (!fp && hi_n != 0 |-> hi_n == 30)
		else $error("pulse width");
	a_frame_period: assert property (fp && hi_n == 0 && seen |-> gap_n == 31249)
		else $error("frame period");
	a_status_edge: assert property ($changed({normal_status, holdover_status,
		freerun_status}) |-> frame_start)
		else $error("status off frame edge");
	a_freerun_comp: assert property ($rose(freerun_status) |-> !phase_step_comp_enable)
		else $error("comp on in freerun");
	a_hold_comp: assert property ($rose(holdover_status) |-> !phase_step_comp_enable)
		else $error("comp on in holdover");
	a_freerun_osc: assert property (freerun_status && $past(freerun_status)
		|-> use_master_oscillator)
		else $error("oscillator not used");
	a_fast_bypass: assert property (fast_normal |-> limiter_bypass)
		else $error("no bypass");
	a_freq_frozen: assert property (age > 8 |-> $stable(ref_freq_active))
		else $error("freq moved");
endmodule : dmsc_core_props
bind dmsc_core dmsc_core_props i_dmsc_core_props (.ref_clk, .reset, .clk_en, .rapid_acquire_enable,
	.frame_pulse_active_high, .normal_status, .holdover_status, .freerun_status,
	.phase_step_comp_enable, .use_master_oscillator, .limiter_bypass, .ref_freq_active);
`default_nettype wire

// ==== sim/test_dpll_mode_state_control.sv ====
// self-checking bench for the mode state control block
`timescale 1ns/10ps
`default_nettype none
module test_dpll_mode_state_control;
	import dmsc_pkg::*;
	typedef struct packed {logic [1:0] mode; logic [3:0] exp;} dmsc_row_t;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic rapid = 1'b0;
	logic en = 1'b1;
	logic [1:0] mode_cmd = MODE_NORMAL;
	logic [1:0] freq_cmd = FREQ_2048K;
	logic lo, hi, flo, fhi, pulse, nrm, hold, frun, comp, osc, byp, fres;
	logic [1:0] fact;
	int fails = 0;
	int n_compared = 0;
	int cycles = 0;
	// status {normal, holdover, freerun, oscillator}; code 11 must keep freerun
	dmsc_row_t rows[3] = '{'{MODE_HOLDOVER, 4'h4}, '{MODE_FREERUN, 4'h3},
		'{MODE_RESERVED, 4'h3}};
	dmsc_host i_dmsc_host (.ref_clk, .mode_cmd, .freq_cmd, .op_mode_select_lo(lo),
		.op_mode_select_hi(hi), .ref_freq_choice_lo(flo), .ref_freq_choice_hi(fhi));
	dmsc_core i_dmsc_core (.ref_clk, .reset, .clk_en(en), .op_mode_select_lo(lo),
		.op_mode_select_hi(hi), .ref_select(1'b0), .ref_freq_choice_lo(flo),
		.ref_freq_choice_hi(fhi), .rapid_acquire_enable(rapid),
		.phase_step_comp_request(1'b1), .reference_invalid(1'b0), .loop_locked(1'b0),
		.loop_freq_word(32'h0), .frame_pulse_active_high(pulse), .normal_status(nrm),
		.holdover_status(hold), .freerun_status(frun), .phase_step_comp_enable(comp),
		.active_reference_b(), .use_master_oscillator(osc), .limiter_bypass(byp),
		.lock_timeout(), .ref_freq_active(fact), .ref_freq_reserved(fres),
		.holdover_freq_word());
	initial begin
		forever #2 ref_clk = ~ref_clk;
	end
	// ===========================================================
	// tasks
	task automatic tick();
		@(posedge ref_clk);
		#1;
	endtask : tick
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// frames are long, so the bound is one frame and a little
	task automatic next_frame();
		int n;
		n = 0;
		while (pulse === 1'b1) tick();
		while (pulse !== 1'b1 && n < 32000) begin
			tick();
			n++;
		end
		if (n == 32000) fails++;
	endtask : next_frame
	task automatic complete_run();
		if (fails == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : complete_run
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 100000) begin
			fails++;
			complete_run();
		end
	end
	// ===========================================================
	// main sequence
	initial begin
		repeat (3) tick();
		reset = 1'b0;
		next_frame();
		chk({28'h0, nrm, hold, frun, osc}, 32'h8);
		freq_cmd = FREQ_8K;
		for (int i = 0; i < 3; i++) begin
			mode_cmd = rows[i].mode;
			next_frame();
			chk({28'h0, nrm, hold, frun, osc}, {28'h0, rows[i].exp});
			chk({31'h0, comp}, 32'h0);
			chk({30'h0, fact}, {30'h0, FREQ_2048K});
		end
		// reset during the frame pulse takes the new frequency and fast lock
		rapid = 1'b1;
		mode_cmd = MODE_NORMAL;
		reset = 1'b1;
		repeat (3) tick();
		reset = 1'b0;
		repeat (10) tick();
		// enable low in mid-pulse must hold the pulse past its 30 cycles
		en = 1'b0;
		repeat (40) tick();
		chk({31'h0, pulse}, 32'h1);
		en = 1'b1;
		repeat (40) tick();
		chk({29'h0, fres, fact}, {29'h0, 1'b0, FREQ_8K});
		chk({28'h0, nrm, hold, frun, byp}, 32'h9);
		complete_run();
	end
endmodule : test_dpll_mode_state_control
`default_nettype wire
